// ==== sbg_pkg.sv ====
// Constants shared by the serial baud-rate generator.
package sbg_pkg;
  // Register addresses on the plain register port.
  localparam logic [15:0] SBG_ADR_RELOAD = 16'hFEB4;
  localparam logic [15:0] SBG_ADR_FDV = 16'hFEB6;
  localparam logic [15:0] SBG_ADR_CTRL = 16'hFEB8;
  // Field widths.
  localparam int SBG_TMR_W = 13;
  localparam int SBG_FDV_W = 9;
  // Control register bit positions.
  localparam int SBG_CTRL_RUN = 0;
  localparam int SBG_CTRL_FDE = 1;
  localparam int SBG_CTRL_BRS = 2;
  localparam int SBG_CTRL_ASYNC = 3;
  // Reset values.
  localparam logic [12:0] SBG_RELOAD_RST = 13'h0000;
  localparam logic [8:0] SBG_FDV_RST = 9'h000;
  localparam logic [3:0] SBG_CTRL_RST = 4'h0;
  // Sixteen sample ticks per bit; phase values of the 7th, 8th and 9th tick.
  localparam logic [3:0] SBG_PHASE_LAST = 4'hF;
  localparam logic [3:0] SBG_PHASE_S7 = 4'h6;
  localparam logic [3:0] SBG_PHASE_S8 = 4'h7;
  localparam logic [3:0] SBG_PHASE_S9 = 4'h8;
endpackage

// ==== sbg_top.sv ====
// Baud-rate generator: prescaler, 13-bit reload timer, bit clock and rx sampler.
module sbg_top
  import sbg_pkg::*;
#(
  parameter int FIX_DIV0 = 2,
  parameter int FIX_DIV1 = 3
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Serial receive pin.
  input wire logic rx_pin,
  // Clock and data outputs.
  output logic sample_clock,
  output logic bit_tick,
  output logic rx_bit,
  output logic rx_valid
);

  typedef struct packed {
    logic [15:0] rdata;
    logic [12:0] reload;
    logic [8:0] fdv;
    logic run;
    logic fde;
    logic brs;
    logic async_mode;
    logic pend;
    logic [12:0] timer;
    logic [1:0] presc;
    logic [8:0] facc;
    logic samp;
    logic [3:0] phase;
    logic bit_tk;
    logic rx_s1;
    logic rx_s2;
    logic smp7;
    logic smp8;
    logic rx_bit;
    logic rx_valid;
  } sbg_state_s;

  sbg_state_s st_q;
  sbg_state_s st_d;
  logic div_tick;
  logic tick;
  logic wr_reload;
  logic [9:0] fsum;

  // Majority of three samples.
  function automatic logic sbg_maj(input logic a, input logic b, input logic c);
    sbg_maj = (a & b) | (a & c) | (b & c);
  endfunction

  assign wr_reload = reg_wr && (reg_addr == SBG_ADR_RELOAD);

  // Next-state logic for the whole block.
  always_comb begin
    st_d = st_q;
    st_d.samp = 1'b0;
    st_d.bit_tk = 1'b0;
    st_d.rx_valid = 1'b0;
    div_tick = 1'b0;
    tick = 1'b0;
    fsum = {1'b0, st_q.facc} + {1'b0, st_q.fdv};
    // Pin synchroniser; only the second stage is looked at.
    st_d.rx_s1 = rx_pin;
    st_d.rx_s2 = st_q.rx_s1;
    // Prescaler: fractional accumulator or one of two fixed dividers.
    if (st_q.run) begin
      if (st_q.fde) begin
        st_d.facc = fsum[8:0];
        div_tick = fsum[9];
        st_d.presc = 2'h0;
      end else if (st_q.presc == 2'((st_q.brs ? FIX_DIV1 : FIX_DIV0) - 1)) begin
        st_d.presc = 2'h0;
        div_tick = 1'b1;
      end else begin
        st_d.presc = st_q.presc + 2'h1;
      end
    end
    // Reload timer counts prescaler ticks and emits the sample clock.
    if (div_tick) begin
      if (st_q.timer == 13'h0000) begin
        st_d.timer = st_q.reload;
        tick = 1'b1;
      end else begin
        st_d.timer = st_q.timer - 13'h0001;
      end
    end
    // A deferred reload fires once the channel runs.
    if (st_q.pend && st_q.run) begin
      st_d.timer = st_q.reload;
      st_d.pend = 1'b0;
    end
    // Register writes. A reload write wins over counting in the same cycle.
    if (reg_wr) begin
      case (reg_addr)
        SBG_ADR_RELOAD: begin
          st_d.reload = reg_wdata[12:0];
          if (st_q.run) begin
            st_d.timer = reg_wdata[12:0];
            st_d.pend = 1'b0;
          end else begin
            st_d.pend = 1'b1;
          end
        end
        SBG_ADR_FDV: st_d.fdv = reg_wdata[8:0];
        SBG_ADR_CTRL: begin
          st_d.run = reg_wdata[SBG_CTRL_RUN];
          st_d.fde = reg_wdata[SBG_CTRL_FDE];
          st_d.brs = reg_wdata[SBG_CTRL_BRS];
          st_d.async_mode = reg_wdata[SBG_CTRL_ASYNC];
        end
        default: st_d.rdata = st_q.rdata;
      endcase
    end
    // Bit clock and sampling. Sync mode takes one bit per sample tick.
    if (tick) begin
      st_d.samp = 1'b1;
      if (st_q.async_mode) begin
        st_d.phase = st_q.phase + 4'h1;
        st_d.bit_tk = (st_q.phase == SBG_PHASE_LAST);
        if (st_q.phase == SBG_PHASE_S7) begin
          st_d.smp7 = st_q.rx_s2;
        end
        if (st_q.phase == SBG_PHASE_S8) begin
          st_d.smp8 = st_q.rx_s2;
        end
        if (st_q.phase == SBG_PHASE_S9) begin
          st_d.rx_bit = sbg_maj(st_q.smp7, st_q.smp8, st_q.rx_s2);
          st_d.rx_valid = 1'b1;
        end
      end else begin
        st_d.phase = 4'h0;
        st_d.bit_tk = 1'b1;
        st_d.rx_bit = st_q.rx_s2;
        st_d.rx_valid = 1'b1;
      end
    end
    // Read data stand in the cycle after the read strobe only.
    st_d.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        SBG_ADR_RELOAD: st_d.rdata = {3'h0, st_q.timer};
        SBG_ADR_FDV: st_d.rdata = {7'h00, st_q.fdv};
        SBG_ADR_CTRL: st_d.rdata = {12'h000, st_q.async_mode, st_q.brs, st_q.fde, st_q.run};
        default: st_d.rdata = 16'h0000;
      endcase
    end
  end

  // State register; reset loads constants only.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.reload <= SBG_RELOAD_RST;
      st_q.fdv <= SBG_FDV_RST;
      {st_q.async_mode, st_q.brs, st_q.fde, st_q.run} <= SBG_CTRL_RST;
      st_q.rx_s1 <= 1'b1;
      st_q.rx_s2 <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state flops.
  assign reg_rdata = st_q.rdata;
  assign sample_clock = st_q.samp;
  assign bit_tick = st_q.bit_tk;
  assign rx_bit = st_q.rx_bit;
  assign rx_valid = st_q.rx_valid;

  // Checks on the design's own behaviour.
  a_read_timer: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == SBG_ADR_RELOAD |=> reg_rdata == {3'h0, $past(st_q.timer)})
    else $error("Reload read did not return the timer count.");
  a_reload_store: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_reload |=> st_q.reload == $past(reg_wdata[12:0]))
    else $error("Reload write was not stored.");
  a_reload_run: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_reload && st_q.run |=> st_q.timer == $past(reg_wdata[12:0]) && !st_q.pend)
    else $error("Running reload write did not reload the timer.");
  a_reload_defer: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_reload && !st_q.run |=> st_q.pend && st_q.timer == $past(st_q.timer))
    else $error("Stopped reload write was not deferred.");
  a_defer_fire: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.pend && st_q.run && !reg_wr |=> st_q.timer == $past(st_q.reload) && !st_q.pend)
    else $error("Deferred reload did not fire once running.");
  a_async_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && st_q.async_mode |=> bit_tick == ($past(st_q.phase) == SBG_PHASE_LAST))
    else $error("Bit tick not on the sixteenth sample tick.");
  a_sample_point: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_valid && $past(st_q.async_mode) |-> st_q.phase == 4'h9 && sample_clock == 1'b1)
    else $error("Async bit resolved off the ninth sample tick.");
  a_majority: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && st_q.async_mode && st_q.phase == SBG_PHASE_S9
    |=> rx_bit == sbg_maj($past(st_q.smp7), $past(st_q.smp8), $past(st_q.rx_s2)))
    else $error("Received bit is not the majority of its samples.");
  a_frac_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.run && st_q.fde && st_q.fdv == 9'h000 && !st_q.pend && !reg_wr
    |=> st_q.timer == $past(st_q.timer))
    else $error("Zero fraction still advanced the timer.");
  a_timer_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    div_tick && st_q.timer != 13'h0000 && !st_q.pend && !wr_reload
    |=> st_q.timer == $past(st_q.timer) - 13'h0001)
    else $error("Timer did not count down by one.");

  // Further checks on the register port, the prescaler and the sampler.
  // They watch internal state as well as pins, so a broken path is caught
  // close to where it breaks rather than many ticks later at the outputs.

  a_rdata_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("Read data not zero outside a read.");

  a_read_unmapped: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr != SBG_ADR_RELOAD && reg_addr != SBG_ADR_FDV
    && reg_addr != SBG_ADR_CTRL |=> reg_rdata == 16'h0000)
    else $error("Unmapped read returned data.");

  a_read_fdv: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == SBG_ADR_FDV |=> reg_rdata == {7'h00, $past(st_q.fdv)})
    else $error("Fraction read returned the wrong value.");

  a_read_ctrl: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == SBG_ADR_CTRL |=> reg_rdata == {12'h000, $past(st_q.async_mode),
    $past(st_q.brs), $past(st_q.fde), $past(st_q.run)})
    else $error("Control read returned the wrong value.");

  a_stop_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !st_q.run && !reg_wr |=> st_q.timer == $past(st_q.timer))
    else $error("Timer moved while the channel was stopped.");

  a_presc_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !st_q.run |=> st_q.presc == $past(st_q.presc) && st_q.facc == $past(st_q.facc))
    else $error("Prescaler moved while the channel was stopped.");

  a_fixed_tick: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.run && !st_q.fde && !st_q.brs && st_q.presc == 2'(FIX_DIV0 - 1) |-> div_tick)
    else $error("Fixed divider missed its tick.");

  a_frac_acc: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.run && st_q.fde |=> st_q.facc == 9'($past(st_q.facc) + $past(st_q.fdv)))
    else $error("Fraction accumulator did not add the fraction.");

  a_tick_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> sample_clock == $past(tick))
    else $error("Sample clock pulse does not follow the timer underflow.");

  a_bit_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    !tick |=> !bit_tick && !rx_valid)
    else $error("Bit tick or valid without a sample tick.");

  a_sync_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && !st_q.async_mode |=> bit_tick && rx_valid && st_q.phase == 4'h0)
    else $error("Sync mode did not give one bit per sample tick.");

  a_phase_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && st_q.async_mode |=> st_q.phase == 4'($past(st_q.phase) + 4'h1))
    else $error("Sample phase did not advance by one.");

  a_take_s7: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && st_q.async_mode && st_q.phase == SBG_PHASE_S7 |=> st_q.smp7 == $past(st_q.rx_s2))
    else $error("Seventh sample not taken.");

  a_take_s8: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick && st_q.async_mode && st_q.phase == SBG_PHASE_S8 |=> st_q.smp8 == $past(st_q.rx_s2))
    else $error("Eighth sample not taken.");

  a_pend_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.pend && !st_q.run |=> st_q.pend)
    else $error("Deferred reload lost before the channel ran.");

endmodule

// ==== tb_serial_baudrate_generator.sv ====
// Self-checking testbench of the serial baud-rate generator.
module tb_serial_baudrate_generator;
  timeunit 1ns;
  timeprecision 1ps;
  import sbg_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_pin = 1'b1;
  logic rd_q = 1'b0;
  logic [15:0] reg_rdata;
  logic sample_clock, bit_tick, rx_bit, rx_valid;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic [15:0] fv;
  logic [12:0] rl;
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 32'h32518B0E;
  int cyc, tk, dv;

  sbg_top #(.FIX_DIV0(2), .FIX_DIV1(3)) sbg_top_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_pin(rx_pin), .sample_clock(sample_clock),
    .bit_tick(bit_tick), .rx_bit(rx_bit), .rx_valid(rx_valid));

  // Free-running 100 MHz clock.
  initial forever #5 core_clk = ~core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d.", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // An idle cycle follows each strobe so no strobe is assigned twice in one step.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read data stand only in the cycle after the strobe; the port idles at zero.
  always @(posedge core_clk) begin
    if (rd_q === 1'b1) begin
      check(reg_rdata & msk_q[0], exp_q.pop_front());
      void'(msk_q.pop_front());
    end else if (!sys_rst) begin
      check(reg_rdata, 16'h0000);
    end
    rd_q <= reg_rd;
  end

  function automatic logic sig(input int s);
    case (s)
      0: return sample_clock;
      1: return bit_tick;
      2: return rx_valid;
      default: return 1'b1;
    endcase
  endfunction

  // Counts cycles and sample ticks from one pulse to the next; bounded so a hang ends.
  task automatic span(input int f, input int t);
    cyc = 0;
    tk = 0;
    while (sig(f) !== 1'b1 && cyc < 4000) begin
      @(posedge core_clk);
      cyc++;
    end
    cyc = 0;
    do begin
      @(posedge core_clk);
      cyc++;
      tk += int'(sample_clock);
    end while (sig(t) !== 1'b1 && cyc < 4000);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(SBG_ADR_RELOAD, 16'h0000, 16'hFFFF);
    rd(16'hFEBA, 16'h0000, 16'hFFFF);
    fv = 16'($random(seed));
    wr(SBG_ADR_FDV, fv);
    rd(SBG_ADR_FDV, {7'h00, fv[8:0]}, 16'h01FF);
    rl = 13'h0005 + 13'($unsigned($random(seed)) % 11);
    wr(SBG_ADR_RELOAD, {3'b111, rl});
    rd(SBG_ADR_RELOAD, 16'h0000, 16'hFFFF);
    // Fixed dividers of both selects, then fractions 256/512 and 128/512.
    for (int i = 0; i < 4; i++) begin
      dv = (i == 1) ? 3 : (i == 3) ? 4 : 2;
      wr(SBG_ADR_CTRL, 16'h0000);
      wr(SBG_ADR_FDV, (i == 2) ? 16'h0100 : 16'h0080);
      wr(SBG_ADR_RELOAD, {3'b000, rl});
      wr(SBG_ADR_CTRL, 16'({(i == 1), (i > 1), 1'b1}));
      span(3, 0);
      check(32'(cyc >= rl * dv), 32'h1);
      span(0, 0);
      check(cyc, (rl + 1) * dv);
      rd(SBG_ADR_RELOAD, 16'h0000, 16'hE000);
    end
    wr(SBG_ADR_CTRL, 16'h0000);
    wr(SBG_ADR_FDV, 16'h0000);
    wr(SBG_ADR_CTRL, 16'h0003);
    tk = 0;
    repeat (600) begin
      @(posedge core_clk);
      tk += int'(sample_clock);
    end
    check(tk, 0);
    wr(SBG_ADR_CTRL, 16'h0000);
    wr(SBG_ADR_CTRL, 16'h0009);
    span(1, 1);
    check(tk, 16);
    check(cyc, 32 * (rl + 1));
    // The pin is held a whole bit so the second resolved bit sees only the new level.
    for (int b = 0; b < 2; b++) begin
      rx_pin <= (b == 0) ? 1'($random(seed)) : ~rx_pin;
      span(2, 2);
      check(rx_bit, rx_pin);
      span(2, 1);
      check(tk, 7);
    end
    end_sim();
  end

  // Watchdog well beyond the longest expected run.
  initial begin
    #600000;
    n_mismatch++;
    end_sim();
  end
endmodule
